// File: dv/canopen_host_model.sv
module canopen_host_model (
  input wire logic clk_sys,
  output logic alarmRaise,
  output logic [15:0] alarmCode,
  output logic [31:0] alarmValFixed,
  output logic [31:0] alarmValFloat,
  output logic alarmGone,
  output logic [15:0] alarmGoneCode,
  output logic [1:0] canState,
  output logic busPresent,
  output logic alarmLimit,
  output logic errCtrlEvent,
  output logic fwAwaitPower,
  output logic fwBadCard,
  output logic fwUpdating
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // alarm events and network levels
  initial
  begin
    alarmRaise = 1'b0;
    alarmGone = 1'b0;
    alarmCode = 16'h0000;
    alarmGoneCode = 16'h0000;
    alarmValFixed = 32'h0000_0000;
    alarmValFloat = 32'h0000_0000;
    canState = 2'h2;
    {busPresent, alarmLimit, errCtrlEvent, fwAwaitPower, fwBadCard, fwUpdating} = 6'h20;
  end

  // data lines show inverse once the pulse is over
  task automatic raise(input logic [15:0] c, input logic [31:0] v);
    @(posedge clk_sys);
    alarmRaise <= 1'b1;
    alarmCode <= c;
    alarmValFixed <= v;
    alarmValFloat <= ~v;
    @(posedge clk_sys);
    alarmRaise <= 1'b0;
    alarmCode <= ~c;
    alarmValFixed <= ~v;
    alarmValFloat <= v;
  endtask

  task automatic gone(input logic [15:0] c);
    @(posedge clk_sys);
    alarmGone <= 1'b1;
    alarmGoneCode <= c;
    @(posedge clk_sys);
    alarmGone <= 1'b0;
    alarmGoneCode <= ~c;
  endtask

  // f: present, limit, error control, await power, bad card, updating
  task automatic setNet(input logic [1:0] st, input logic [5:0] f);
    canState <= st;
    {busPresent, alarmLimit, errCtrlEvent, fwAwaitPower, fwBadCard, fwUpdating} <= f;
  endtask
endmodule // canopen_host_model

// File: dv/tb_diag_event_logger.sv
module tb_diag_event_logger;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, regWrite, regRead, alarmRaise, alarmGone, busPresent, alarmLimit;
  logic errCtrlEvent, fwAwaitPower, fwBadCard, fwUpdating, alarmBusy;
  logic busLedRed, busLedGreen, rdyLedRed, rdyLedGreen;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, alarmValFixed, alarmValFloat;
  logic [15:0] alarmCode, alarmGoneCode, statusWordOne;
  logic [1:0] canState;
  int error_cnt = 0;
  int tests_run = 0;

  diag_event_logger #(.MS_CYCLES(10)) diag_event_logger_inst (.clk_sys, .rst, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .alarmRaise, .alarmCode, .alarmValFixed,
    .alarmValFloat, .alarmGone, .alarmGoneCode, .canState, .busPresent, .alarmLimit,
    .errCtrlEvent, .fwAwaitPower, .fwBadCard, .fwUpdating, .alarmBusy, .statusWordOne,
    .busLedRed, .busLedGreen, .rdyLedRed, .rdyLedGreen);
  canopen_host_model canopen_host_model_inst (.clk_sys, .alarmRaise, .alarmCode,
    .alarmValFixed, .alarmValFloat, .alarmGone, .alarmGoneCode, .canState, .busPresent,
    .alarmLimit, .errCtrlEvent, .fwAwaitPower, .fwBadCard, .fwUpdating);

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========
  // checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, $sformatf("reg %h", a));
  endtask

  task automatic ent(input logic [5:0] idx, input logic [15:0] code);
    wr(diag_pkg::REG_SELECT, 32'(idx));
    rdChk(diag_pkg::REG_CODE, 32'(code));
  endtask

  task automatic waitIdle;
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (alarmBusy === 1'b1)
        seen = 1'b1;
      else if (seen)
        break;
    end
    if (i == 40)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic led(input logic [1:0] st, input logic [5:0] f, input int n, input int er,
                     input int eg, input int ey);
    int r, g, y, q;
    r = 0;
    g = 0;
    y = 0;
    q = 0;
    @(posedge clk_sys);
    canopen_host_model_inst.setNet(st, f);
    repeat (4) @(posedge clk_sys);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
      r += int'(busLedRed === 1'b1);
      g += int'(busLedGreen === 1'b1);
      y += int'(rdyLedRed === 1'b1);
      q += int'(rdyLedGreen === 1'b1);
    end
    if (er >= 0)
    begin
      chk(r, er, "bus red");
      chk(g, eg, "bus green");
    end
    chk(y, ey, "ready red");
    chk(q, (ey == 0) ? n : 0, "ready green");
  endtask

  // ==========
  // scenarios
  task automatic testRuntime;
    logic [31:0] a, b;
    rd(diag_pkg::REG_RT_MS, a);
    wr(diag_pkg::REG_RT_MS, 32'h0000_0000);
    repeat (96) @(posedge clk_sys);
    rd(diag_pkg::REG_RT_MS, b);
    chk(b, a + 32'h0000_000A, "runtime ms");
    rdChk(diag_pkg::REG_RT_DAYS, 32'h0000_0000);
    $display("test runtime done");
  endtask

  task automatic testAlarms;
    logic [31:0] t, d;
    fork
      rd(diag_pkg::REG_RT_MS, t);
      canopen_host_model_inst.raise(16'h0001, 32'h0000_1234);
    join
    @(posedge clk_sys);
    #1;
    chk(statusWordOne[7], 32'h0000_0001, "alarm bit");
    rdChk(diag_pkg::REG_COUNTER, 32'h0000_0001);
    wr(diag_pkg::REG_SELECT, 32'h0000_0000);
    rdChk(diag_pkg::REG_CODE, 32'h0000_0001);
    rdChk(diag_pkg::REG_FIXED, 32'h0000_1234);
    rdChk(diag_pkg::REG_FLOAT, 32'hFFFF_EDCB);
    rdChk(diag_pkg::REG_RECV_MS, t);
    rdChk(diag_pkg::REG_RECV_DAYS, 32'h0000_0000);
    repeat (30) @(posedge clk_sys);
    canopen_host_model_inst.gone(16'h0001);
    @(posedge clk_sys);
    #1;
    chk(statusWordOne[7], 32'h0000_0000, "alarm bit");
    rdChk(diag_pkg::REG_CODE, 32'h0000_0001);
    rd(diag_pkg::REG_REM_MS, d);
    chk(32'(d > t), 32'h0000_0001, "removed ms");
    rdChk(diag_pkg::REG_REM_DAYS, 32'h0000_0000);
    for (int k = 2; k < 9; k++)
      canopen_host_model_inst.raise(16'(k), 32'(k));
    rdChk(diag_pkg::REG_FILL, 32'h0000_0008);
    $display("test alarms done");
  endtask

  task automatic testHistory;
    canopen_host_model_inst.raise(16'h0009, 32'h0000_0009);
    waitIdle();
    rdChk(diag_pkg::REG_FILL, 32'h0000_0108);
    ent(6'h08, 16'h0001);
    ent(6'h00, 16'h0002);
    ent(6'h07, 16'h0009);
    canopen_host_model_inst.raise(16'h000A, 32'h0000_000A);
    ent(6'h06, 16'h000A);
    ent(6'h07, 16'h0009);
    rdChk(diag_pkg::REG_FILL, 32'h0000_0108);
    rdChk(diag_pkg::REG_COUNTER, 32'h0000_000A);
    canopen_host_model_inst.gone(16'h0002);
    canopen_host_model_inst.gone(16'h0003);
    wr(diag_pkg::REG_COUNTER, 32'h0000_0000);
    waitIdle();
    rdChk(diag_pkg::REG_FILL, 32'h0000_0306);
    rdChk(diag_pkg::REG_COUNTER, 32'h0000_0000);
    ent(6'h08, 16'h0003);
    ent(6'h09, 16'h0002);
    ent(6'h0A, 16'h0001);
    ent(6'h00, 16'h0004);
    $display("test history done");
  endtask

  task automatic testLeds;
    led(diag_pkg::CAN_OPERATIONAL, 6'h20, 4000, 0, 4000, 0);
    led(diag_pkg::CAN_PREOP, 6'h20, 4000, 0, 2000, 0);
    led(diag_pkg::CAN_STOPPED, 6'h20, 14000, 0, 2000, 0);
    led(diag_pkg::CAN_OPERATIONAL, 6'h00, 4000, 4000, 0, 0);
    led(diag_pkg::CAN_OPERATIONAL, 6'h30, 14000, 2000, 0, 0);
    led(diag_pkg::CAN_OPERATIONAL, 6'h28, 14000, 4000, 0, 0);
    led(diag_pkg::CAN_OPERATIONAL, 6'h24, 10000, 5000, 0, 5000);
    led(diag_pkg::CAN_OPERATIONAL, 6'h22, 4000, 2000, 0, 2000);
    led(diag_pkg::CAN_OPERATIONAL, 6'h21, 10000, 4000, 4000, 10000);
    $display("test leds done");
  endtask

  initial
  begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    testRuntime();
    testAlarms();
    testHistory();
    testLeds();
    summarize();
  end
endmodule // tb_diag_event_logger

// File: rtl/diag_event_logger.sv
// Decided for this implementation: strobed register access and the register addresses.
module diag_event_logger #(
  parameter int unsigned MS_CYCLES = diag_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic alarmRaise,
  input wire logic [15:0] alarmCode,
  input wire logic [31:0] alarmValFixed,
  input wire logic [31:0] alarmValFloat,
  input wire logic alarmGone,
  input wire logic [15:0] alarmGoneCode,
  input wire logic [1:0] canState,
  input wire logic busPresent,
  input wire logic alarmLimit,
  input wire logic errCtrlEvent,
  input wire logic fwAwaitPower,
  input wire logic fwBadCard,
  input wire logic fwUpdating,
  output logic alarmBusy,
  output logic [15:0] statusWordOne,
  output logic busLedRed,
  output logic busLedGreen,
  output logic rdyLedRed,
  output logic rdyLedGreen
);

  // ==========================================================
  // millisecond tick and runtime
  logic [13:0] tickCnt;
  logic msTick;
  logic [31:0] rtMs;
  logic [31:0] rtDays;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tickCnt <= 14'h0000;
      msTick <= 1'b0;
    end
    else if (tickCnt == 14'(MS_CYCLES - 1))
    begin
      tickCnt <= 14'h0000;
      msTick <= 1'b1;
    end
    else
    begin
      tickCnt <= tickCnt + 14'h0001;
      msTick <= 1'b0;
    end
  end

  // reset is power-up only; no write path reaches the runtime
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rtMs <= 32'h0000_0000;
      rtDays <= 32'h0000_0000;
    end
    else if (msTick)
    begin
      if (rtMs == diag_pkg::MS_LAST)
      begin
        rtMs <= 32'h0000_0000;
        rtDays <= rtDays + 32'h0000_0001;
      end
      else
      begin
        rtMs <= rtMs + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // alarm buffer
  diag_pkg::entry_t bufEntry [diag_pkg::BUF_DEPTH];
  logic bufValid [diag_pkg::BUF_DEPTH];
  logic bufRemoved [diag_pkg::BUF_DEPTH];
  logic [3:0] bufCount;
  diag_pkg::move_state_t moveState;
  logic [2:0] scanIdx;
  logic [3:0] wrIdx;
  logic pending;
  diag_pkg::entry_t pendEntry;
  logic [31:0] alarmCount;
  logic acceptRaise;
  logic counterZeroWr;
  logic anyRemoved;
  logic anyActive;
  logic goneHit;
  logic [2:0] goneIdx;
  logic startMove;
  diag_pkg::entry_t newEntry;

  always_comb
  begin
    anyRemoved = 1'b0;
    anyActive = 1'b0;
    goneHit = 1'b0;
    goneIdx = 3'h0;
    for (int i = diag_pkg::BUF_DEPTH - 1; i >= 0; i--)
    begin
      if (bufValid[i] && bufRemoved[i])
        anyRemoved = 1'b1;
      if (bufValid[i] && !bufRemoved[i])
        anyActive = 1'b1;
      if (bufValid[i] && !bufRemoved[i] && bufEntry[i].code == alarmGoneCode)
      begin
        goneHit = 1'b1;
        goneIdx = 3'(i);
      end
    end
  end

  always_comb
  begin
    acceptRaise = alarmRaise && !alarmBusy;
    counterZeroWr = regWrite && regAddr == diag_pkg::REG_COUNTER && regWdata == 32'h0000_0000;
    startMove = !alarmBusy && (counterZeroWr ||
      (acceptRaise && bufCount == diag_pkg::BUF_FULL && anyRemoved));
    newEntry.code = alarmCode;
    newEntry.valFixed = alarmValFixed;
    newEntry.valFloat = alarmValFloat;
    newEntry.recvDays = rtDays;
    newEntry.recvMs = rtMs;
    newEntry.remDays = 32'h0000_0000;
    newEntry.remMs = 32'h0000_0000;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < diag_pkg::BUF_DEPTH; i++)
      begin
        bufEntry[i] <= '0;
        bufValid[i] <= 1'b0;
        bufRemoved[i] <= 1'b0;
      end
      bufCount <= 4'h0;
      moveState <= diag_pkg::MV_IDLE;
      scanIdx <= 3'h0;
      wrIdx <= 4'h0;
      pending <= 1'b0;
      pendEntry <= '0;
      alarmBusy <= 1'b0;
    end
    else
    begin
      case (moveState)
        diag_pkg::MV_IDLE:
        begin
          if (alarmGone && goneHit)
          begin
            bufRemoved[goneIdx] <= 1'b1;
            bufEntry[goneIdx].remDays <= rtDays;
            bufEntry[goneIdx].remMs <= rtMs;
          end
          if (acceptRaise)
          begin
            if (bufCount != diag_pkg::BUF_FULL)
            begin
              bufEntry[bufCount[2:0]] <= newEntry;
              bufValid[bufCount[2:0]] <= 1'b1;
              bufRemoved[bufCount[2:0]] <= 1'b0;
              bufCount <= bufCount + 4'h1;
            end
            else if (!anyRemoved)
            begin
              bufEntry[diag_pkg::OVERWRITE_SLOT] <= newEntry;
              bufValid[diag_pkg::OVERWRITE_SLOT] <= 1'b1;
              bufRemoved[diag_pkg::OVERWRITE_SLOT] <= 1'b0;
            end
            else
            begin
              pending <= 1'b1;
              pendEntry <= newEntry;
            end
          end
          if (startMove)
          begin
            moveState <= diag_pkg::MV_SCAN;
            scanIdx <= 3'h0;
            wrIdx <= 4'h0;
            alarmBusy <= 1'b1;
          end
        end
        diag_pkg::MV_SCAN:
        begin
          if (bufValid[scanIdx] && !bufRemoved[scanIdx])
          begin
            bufEntry[wrIdx[2:0]] <= bufEntry[scanIdx];
            bufValid[wrIdx[2:0]] <= 1'b1;
            bufRemoved[wrIdx[2:0]] <= 1'b0;
            wrIdx <= wrIdx + 4'h1;
          end
          scanIdx <= scanIdx + 3'h1;
          if (scanIdx == diag_pkg::LAST_SLOT)
            moveState <= diag_pkg::MV_FINISH;
        end
        diag_pkg::MV_FINISH:
        begin
          for (int i = 0; i < diag_pkg::BUF_DEPTH; i++)
          begin
            if (4'(i) >= wrIdx)
            begin
              bufValid[i] <= 1'b0;
              bufRemoved[i] <= 1'b0;
            end
          end
          bufCount <= wrIdx;
          if (pending)
          begin
            bufEntry[wrIdx[2:0]] <= pendEntry;
            bufValid[wrIdx[2:0]] <= 1'b1;
            bufRemoved[wrIdx[2:0]] <= 1'b0;
            bufCount <= wrIdx + 4'h1;
          end
          pending <= 1'b0;
          moveState <= diag_pkg::MV_IDLE;
          alarmBusy <= 1'b0;
        end
        default:
        begin
          moveState <= diag_pkg::MV_IDLE;
          alarmBusy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      alarmCount <= 32'h0000_0000;
    else if (regWrite && regAddr == diag_pkg::REG_COUNTER)
      alarmCount <= regWdata + {31'h0000_0000, acceptRaise};
    else if (acceptRaise)
      alarmCount <= alarmCount + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      statusWordOne <= 16'h0000;
    else
      statusWordOne <= 16'(anyActive) << diag_pkg::STATUS_ALARM_BIT;
  end

  // ==========================================================
  // alarm history, index 0 here is visible index 8
  diag_pkg::entry_t hist [diag_pkg::HIST_DEPTH];
  logic [5:0] histCount;
  logic histPush;

  always_comb
  begin
    histPush = moveState == diag_pkg::MV_SCAN && bufValid[scanIdx] && bufRemoved[scanIdx];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < diag_pkg::HIST_DEPTH; i++)
        hist[i] <= '0;
      histCount <= 6'h00;
    end
    else if (histPush)
    begin
      // oldest buffer slot pushed first, so youngest ends at front
      hist[0] <= bufEntry[scanIdx];
      for (int i = 1; i < diag_pkg::HIST_DEPTH; i++)
        hist[i] <= hist[i - 1];
      if (histCount != diag_pkg::HIST_FULL)
        histCount <= histCount + 6'h01;
    end
  end

  // ==========================================================
  // register port
  logic [5:0] entrySel;
  diag_pkg::entry_t selEntry;
  logic [5:0] histSel;

  always_comb
  begin
    histSel = entrySel - diag_pkg::HIST_BASE;
    selEntry = '0;
    if (entrySel < diag_pkg::HIST_BASE)
    begin
      if (bufValid[entrySel[2:0]])
        selEntry = bufEntry[entrySel[2:0]];
    end
    else if (histSel < histCount)
      selEntry = hist[histSel];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      entrySel <= 6'h00;
    else if (regWrite && regAddr == diag_pkg::REG_SELECT)
      entrySel <= regWdata[5:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regRdata <= 32'h0000_0000;
    else if (regRead)
    begin
      case (regAddr)
        diag_pkg::REG_RT_MS: regRdata <= rtMs;
        diag_pkg::REG_RT_DAYS: regRdata <= rtDays;
        diag_pkg::REG_STATUS: regRdata <= {16'h0000, statusWordOne};
        diag_pkg::REG_COUNTER: regRdata <= alarmCount;
        diag_pkg::REG_FILL: regRdata <= {15'h0000, alarmBusy, 2'h0, histCount, 4'h0, bufCount};
        diag_pkg::REG_SELECT: regRdata <= {26'h000_0000, entrySel};
        diag_pkg::REG_CODE: regRdata <= {16'h0000, selEntry.code};
        diag_pkg::REG_FIXED: regRdata <= selEntry.valFixed;
        diag_pkg::REG_FLOAT: regRdata <= selEntry.valFloat;
        diag_pkg::REG_RECV_DAYS: regRdata <= selEntry.recvDays;
        diag_pkg::REG_RECV_MS: regRdata <= selEntry.recvMs;
        diag_pkg::REG_REM_DAYS: regRdata <= selEntry.remDays;
        diag_pkg::REG_REM_MS: regRdata <= selEntry.remMs;
        default: regRdata <= 32'h0000_0000;
      endcase
    end
    else
      regRdata <= 32'h0000_0000;
  end

  // ==========================================================
  // indicator patterns
  logic [10:0] fastMs;
  logic [10:0] slowMs;
  logic [10:0] flashMs;
  logic fastPh;
  logic slowPh;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fastMs <= 11'h000;
      slowMs <= 11'h000;
      flashMs <= 11'h000;
      fastPh <= 1'b0;
      slowPh <= 1'b0;
    end
    else if (msTick)
    begin
      fastMs <= (fastMs == diag_pkg::FAST_HALF_MS - 11'h001) ? 11'h000 : fastMs + 11'h001;
      fastPh <= (fastMs == diag_pkg::FAST_HALF_MS - 11'h001) ? !fastPh : fastPh;
      slowMs <= (slowMs == diag_pkg::SLOW_HALF_MS - 11'h001) ? 11'h000 : slowMs + 11'h001;
      slowPh <= (slowMs == diag_pkg::SLOW_HALF_MS - 11'h001) ? !slowPh : slowPh;
      flashMs <= (flashMs == diag_pkg::FLASH_PERIOD_MS - 11'h001) ? 11'h000 : flashMs + 11'h001;
    end
  end

  function automatic logic patLevel(input diag_pkg::led_pat_t pat, input logic fast,
    input logic slow, input logic [10:0] flash);
    logic second;
    second = flash >= diag_pkg::FLASH_ON_MS + diag_pkg::FLASH_GAP_MS &&
      flash < diag_pkg::FLASH_ON_MS + diag_pkg::FLASH_ON_MS + diag_pkg::FLASH_GAP_MS;
    case (pat)
      diag_pkg::PAT_ON: patLevel = 1'b1;
      diag_pkg::PAT_FAST: patLevel = fast;
      diag_pkg::PAT_SLOW: patLevel = slow;
      diag_pkg::PAT_SINGLE: patLevel = flash < diag_pkg::FLASH_ON_MS;
      diag_pkg::PAT_DOUBLE: patLevel = flash < diag_pkg::FLASH_ON_MS || second;
      diag_pkg::PAT_VAR: patLevel = fast ^ slow;
      default: patLevel = 1'b0;
    endcase
  endfunction

  diag_pkg::led_pat_t busPat;
  diag_pkg::led_pat_t rdyPat;
  logic busRedSel;
  logic busGreenSel;
  logic rdyRedSel;
  logic busLevel;
  logic rdyLevel;

  always_comb
  begin
    busPat = diag_pkg::PAT_OFF;
    busRedSel = 1'b1;
    busGreenSel = 1'b0;
    rdyPat = diag_pkg::PAT_ON;
    rdyRedSel = 1'b0;
    if (fwUpdating)
    begin
      busPat = diag_pkg::PAT_VAR;
      busGreenSel = 1'b1;
      rdyRedSel = 1'b1;
    end
    else if (fwBadCard)
    begin
      busPat = diag_pkg::PAT_FAST;
      rdyPat = diag_pkg::PAT_FAST;
      rdyRedSel = 1'b1;
    end
    else if (fwAwaitPower)
    begin
      busPat = diag_pkg::PAT_SLOW;
      rdyPat = diag_pkg::PAT_SLOW;
      rdyRedSel = 1'b1;
    end
    else if (!busPresent)
      busPat = diag_pkg::PAT_ON;
    else if (errCtrlEvent)
      busPat = diag_pkg::PAT_DOUBLE;
    else if (alarmLimit)
      busPat = diag_pkg::PAT_SINGLE;
    else
    begin
      busRedSel = 1'b0;
      busGreenSel = 1'b1;
      case (canState)
        diag_pkg::CAN_OPERATIONAL: busPat = diag_pkg::PAT_ON;
        diag_pkg::CAN_PREOP: busPat = diag_pkg::PAT_FAST;
        diag_pkg::CAN_STOPPED: busPat = diag_pkg::PAT_SINGLE;
        default: busPat = diag_pkg::PAT_OFF;
      endcase
    end
    busLevel = patLevel(busPat, fastPh, slowPh, flashMs);
    rdyLevel = patLevel(rdyPat, fastPh, slowPh, flashMs);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busLedRed <= 1'b0;
      busLedGreen <= 1'b0;
      rdyLedRed <= 1'b0;
      rdyLedGreen <= 1'b0;
    end
    else
    begin
      busLedRed <= busLevel && busRedSel;
      busLedGreen <= busLevel && busGreenSel;
      rdyLedRed <= rdyLevel && rdyRedSel;
      rdyLedGreen <= rdyLevel && !rdyRedSel;
    end
  end

  // ==========================================================
  // checks
  property p_ms_wrap;
    @(posedge clk_sys) disable iff (rst)
    msTick && rtMs == diag_pkg::MS_LAST |=> rtMs == 32'h0000_0000 && rtDays == $past(rtDays) + 1;
  endproperty
  a_ms_wrap: assert property (p_ms_wrap) else $error("day wrap wrong");

  property p_ms_step;
    @(posedge clk_sys) disable iff (rst)
    msTick && rtMs != diag_pkg::MS_LAST |=> rtMs == $past(rtMs) + 1 && $stable(rtDays);
  endproperty
  a_ms_step: assert property (p_ms_step) else $error("ms step wrong");

  property p_rt_hold;
    @(posedge clk_sys) disable iff (rst)
    !msTick |=> $stable(rtMs) && $stable(rtDays);
  endproperty
  a_rt_hold: assert property (p_rt_hold) else $error("runtime moved off tick");

  property p_status_bit;
    @(posedge clk_sys) disable iff (rst)
    acceptRaise && bufCount != diag_pkg::BUF_FULL && !alarmGone
      |-> ##2 statusWordOne[diag_pkg::STATUS_ALARM_BIT];
  endproperty
  a_status_bit: assert property (p_status_bit) else $error("alarm bit missing");

  property p_count_inc;
    @(posedge clk_sys) disable iff (rst)
    acceptRaise && !(regWrite && regAddr == diag_pkg::REG_COUNTER)
      |=> alarmCount == $past(alarmCount) + 1;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter not bumped");

  property p_recv_stamp;
    @(posedge clk_sys) disable iff (rst)
    acceptRaise && bufCount != diag_pkg::BUF_FULL
      |=> bufEntry[$past(bufCount[2:0])].recvMs == $past(rtMs);
  endproperty
  a_recv_stamp: assert property (p_recv_stamp) else $error("stamp not copied");

  property p_overwrite;
    @(posedge clk_sys) disable iff (rst)
    acceptRaise && bufCount == diag_pkg::BUF_FULL && !anyRemoved
      |=> bufEntry[diag_pkg::OVERWRITE_SLOT].code == $past(alarmCode)
      && bufCount == diag_pkg::BUF_FULL && !alarmBusy;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("overwrite slot wrong");

  property p_full_move;
    @(posedge clk_sys) disable iff (rst)
    startMove |=> alarmBusy [*8] ##1 alarmBusy ##1 !alarmBusy;
  endproperty
  a_full_move: assert property (p_full_move) else $error("move length wrong");

  property p_zero_write;
    @(posedge clk_sys) disable iff (rst)
    counterZeroWr && !alarmBusy |=> alarmBusy && moveState == diag_pkg::MV_SCAN;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write no move");

  property p_hist_cap;
    @(posedge clk_sys) disable iff (rst)
    histCount <= diag_pkg::HIST_FULL;
  endproperty
  a_hist_cap: assert property (p_hist_cap) else $error("history overfull");

  property p_nobus_led;
    @(posedge clk_sys) disable iff (rst)
    !busPresent && !fwUpdating && !fwBadCard && !fwAwaitPower |=> busLedRed && !busLedGreen;
  endproperty
  a_nobus_led: assert property (p_nobus_led) else $error("no bus not red");

  c_overwrite: cover property (@(posedge clk_sys) disable iff (rst)
    acceptRaise && bufCount == diag_pkg::BUF_FULL && !anyRemoved);
  c_move: cover property (@(posedge clk_sys) disable iff (rst) histPush);
  c_wrap: cover property (@(posedge clk_sys) disable iff (rst) msTick && rtMs == diag_pkg::MS_LAST);
  c_double: cover property (@(posedge clk_sys) disable iff (rst) busPat == diag_pkg::PAT_DOUBLE);

endmodule // diag_event_logger

// File: rtl/diag_pkg.sv
package diag_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_TICK_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam logic [31:0] MS_LAST = 32'h0526_5BFF;
  localparam logic [10:0] FAST_HALF_MS = 11'h064;
  localparam logic [10:0] SLOW_HALF_MS = 11'h1f4;
  localparam logic [10:0] FLASH_ON_MS = 11'h0c8;
  localparam logic [10:0] FLASH_GAP_MS = 11'h0c8;
  localparam logic [10:0] FLASH_PERIOD_MS = 11'h578;

  // ==========================================================
  // storage
  localparam int unsigned BUF_DEPTH = 8;
  localparam int unsigned HIST_DEPTH = 56;
  localparam logic [3:0] BUF_FULL = 4'h8;
  localparam logic [2:0] OVERWRITE_SLOT = 3'h6;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [5:0] HIST_BASE = 6'h08;
  localparam logic [5:0] HIST_FULL = 6'h38;
  localparam int unsigned STATUS_ALARM_BIT = 7;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_RT_MS = 8'h00;
  localparam logic [7:0] REG_RT_DAYS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_COUNTER = 8'h0c;
  localparam logic [7:0] REG_FILL = 8'h10;
  localparam logic [7:0] REG_SELECT = 8'h14;
  localparam logic [7:0] REG_CODE = 8'h18;
  localparam logic [7:0] REG_FIXED = 8'h1c;
  localparam logic [7:0] REG_FLOAT = 8'h20;
  localparam logic [7:0] REG_RECV_DAYS = 8'h24;
  localparam logic [7:0] REG_RECV_MS = 8'h28;
  localparam logic [7:0] REG_REM_DAYS = 8'h2c;
  localparam logic [7:0] REG_REM_MS = 8'h30;

  typedef struct packed {
    logic [15:0] code;
    logic [31:0] valFixed;
    logic [31:0] valFloat;
    logic [31:0] recvDays;
    logic [31:0] recvMs;
    logic [31:0] remDays;
    logic [31:0] remMs;
  } entry_t;

  typedef enum logic [1:0] {
    CAN_STOPPED = 2'b00,
    CAN_PREOP = 2'b01,
    CAN_OPERATIONAL = 2'b10,
    CAN_UNKNOWN = 2'b11
  } can_state_t;

  typedef enum logic [2:0] {
    PAT_OFF = 3'b000,
    PAT_ON = 3'b001,
    PAT_FAST = 3'b010,
    PAT_SLOW = 3'b011,
    PAT_SINGLE = 3'b100,
    PAT_DOUBLE = 3'b101,
    PAT_VAR = 3'b110
  } led_pat_t;

  typedef enum logic [1:0] {
    MV_IDLE = 2'b00,
    MV_SCAN = 2'b01,
    MV_FINISH = 2'b10
  } move_state_t;

endpackage
